// file: rtl/pdio_pkg.sv
package pdio_pkg;
	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam int             ADDR_W        = 20;
	localparam logic [19:0]    OFS_PORT_A    = 20'h50000;
	localparam logic [19:0]    OFS_PORT_B    = 20'h50010;
	localparam logic [19:0]    OFS_PORT_C    = 20'h50020;
	localparam logic [19:0]    OFS_CFG       = 20'h50030;

	// ----------------------------------------
	// Control word fields
	// ----------------------------------------
	localparam int             CW_DEFINE     = 7;  // 1: mode definition, 0: port C bit op
	localparam int             CW_A_MODE_HI  = 6;
	localparam int             CW_A_MODE_LO  = 5;
	localparam int             CW_A_IN       = 4;
	localparam int             CW_CU_IN      = 3;
	localparam int             CW_B_MODE     = 2;
	localparam int             CW_B_IN       = 1;
	localparam int             CW_CL_IN      = 0;
	localparam int             CW_BIT_HI     = 3;  // Bit op: select field
	localparam int             CW_BIT_LO     = 1;
	localparam int             CW_BIT_VAL    = 0;
	localparam logic [7:0]     CW_RESET      = 8'h9b;  // All ports basic input

	// ----------------------------------------
	// Port C handshake bit positions
	// ----------------------------------------
	localparam int             PC_OBF_A_N    = 7;
	localparam int             PC_ACK_A_N    = 6;
	localparam int             PC_IBF_A      = 5;
	localparam int             PC_STB_A_N    = 4;
	localparam int             PC_INTR_A     = 3;
	localparam int             PC_HS_B_N     = 2;  // Strobe or acknowledge of port B
	localparam int             PC_FLAG_B     = 1;
	localparam int             PC_INTR_B     = 0;
endpackage : pdio_pkg

// file: rtl/pdio_ports.sv
// Operation
// (RQ1) Four byte registers at 0x50000..0x50030, step 0x10
// (RQ2) Lines grouped as two twelves or three ports
// (RQ3) Port A read returns present line levels; in strobed input the code returns the captured byte instead
// (RQ4) Port A write drives lines when output
// (RQ5) Port B read returns present line levels; in strobed input the code returns the captured byte instead
// (RQ6) Port B write drives lines when output
// (RQ7) Port C plain eight bits without handshakes
// (RQ8) Handshake mode takes over some port C lines
// (RQ9) Control word sets directions, modes; readable
// (RQ10) Top bit: mode define, else C bit op
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pdio_ports
	import pdio_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              rstn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [7:0]        first_port_lines_in,
	output logic      [7:0]        first_port_lines_out,
	output logic      [7:0]        first_port_lines_oe,
	input  wire logic [7:0]        second_port_lines_in,
	output logic      [7:0]        second_port_lines_out,
	output logic      [7:0]        second_port_lines_oe,
	input  wire logic [7:0]        third_port_lines_in,
	output logic      [7:0]        third_port_lines_out,
	output logic      [7:0]        third_port_lines_oe
);

	// ----------------------------------------
	// Mode decode helpers
	// ----------------------------------------
	// Group A strobed when either mode bit is set; the bidirectional
	// code is handled as strobed with the direction from the A input bit
	function automatic logic a_strobed(input logic [7:0] cw);
		a_strobed = cw[CW_A_MODE_HI] | cw[CW_A_MODE_LO];
	endfunction : a_strobed
	function automatic logic b_strobed(input logic [7:0] cw);
		b_strobed = cw[CW_B_MODE];
	endfunction : b_strobed

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0]  a_s1_reg, a_s2_reg;        // Port A synchroniser
	logic [7:0]  b_s1_reg, b_s2_reg;        // Port B synchroniser
	logic [7:0]  c_s1_reg, c_s2_reg;        // Port C synchroniser
	logic [7:0]  c_prev_reg;                // Last synced C, for edges
	logic [7:0]  cw_reg,      cw_next;      // Control word
	logic [7:0]  a_lat_reg,   a_lat_next;   // Port A output latch
	logic [7:0]  b_lat_reg,   b_lat_next;   // Port B output latch
	logic [7:0]  c_lat_reg,   c_lat_next;   // Port C output latch
	logic [7:0]  a_cap_reg,   a_cap_next;   // Port A strobed capture
	logic [7:0]  b_cap_reg,   b_cap_next;   // Port B strobed capture
	logic        a_full_reg,  a_full_next;  // A buffer full (IBF or OBF)
	logic        b_full_reg,  b_full_next;  // B buffer full
	logic        a_intr_reg,  a_intr_next;  // A handshake request
	logic        b_intr_reg,  b_intr_next;  // B handshake request
	logic [7:0]  a_oe_reg,    a_oe_next;
	logic [7:0]  b_oe_reg,    b_oe_next;
	logic [7:0]  c_out_reg,   c_out_next;
	logic [7:0]  c_oe_reg,    c_oe_next;
	logic [31:0] prdata_reg,  prdata_next;
	logic        pready_reg,  pready_next;
	logic        pslverr_reg, pslverr_next;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic        acc_wait;   // Access phase, answer not yet given
	logic        acc_done;   // Completing edge of a transfer
	logic        hit_a, hit_b, hit_c, hit_cw, hit_any;
	logic        wr_ok, rd_ok;
	logic        a_in, b_in, a_hs, b_hs;
	logic        stb_a_fall, stb_a_rise, stb_b_fall, stb_b_rise;
	logic        inte_a, inte_b;
	logic [2:0]  bit_sel;
	assign acc_wait = psel & penable & ~pready_reg;
	assign acc_done = psel & penable & pready_reg;
	assign hit_a    = (paddr == OFS_PORT_A);  // [RQ1]
	assign hit_b    = (paddr == OFS_PORT_B);  // [RQ1]
	assign hit_c    = (paddr == OFS_PORT_C);  // [RQ1]
	assign hit_cw   = (paddr == OFS_CFG);     // [RQ1]
	assign hit_any  = hit_a | hit_b | hit_c | hit_cw;
	// Only the low byte lane carries data; other lanes are dropped
	assign wr_ok    = acc_done & pwrite & hit_any & pstrb[0];
	assign rd_ok    = acc_done & ~pwrite & hit_any;
	// Group A is port A plus upper C, group B is port B plus lower C
	assign a_hs     = a_strobed(cw_reg);  // [RQ2]
	assign b_hs     = b_strobed(cw_reg);  // [RQ2]
	assign a_in     = cw_reg[CW_A_IN];
	assign b_in     = cw_reg[CW_B_IN];
	assign bit_sel  = pwdata[CW_BIT_HI:CW_BIT_LO];
	// Edges of the handshake inputs, seen on synced levels only
	assign stb_a_fall = c_prev_reg[a_in ? PC_STB_A_N : PC_ACK_A_N]
	                  & ~c_s2_reg[a_in ? PC_STB_A_N : PC_ACK_A_N];
	assign stb_a_rise = ~c_prev_reg[a_in ? PC_STB_A_N : PC_ACK_A_N]
	                  & c_s2_reg[a_in ? PC_STB_A_N : PC_ACK_A_N];
	assign stb_b_fall = c_prev_reg[PC_HS_B_N] & ~c_s2_reg[PC_HS_B_N];
	assign stb_b_rise = ~c_prev_reg[PC_HS_B_N] & c_s2_reg[PC_HS_B_N];
	// Request enables live in the C latch, set by single-bit commands
	assign inte_a     = c_lat_reg[a_in ? PC_STB_A_N : PC_ACK_A_N];
	assign inte_b     = c_lat_reg[PC_HS_B_N];
	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	// Handshake flags give set priority over a host clear in one cycle
	always_comb begin
		cw_next      = cw_reg;
		a_lat_next   = a_lat_reg;
		b_lat_next   = b_lat_reg;
		c_lat_next   = c_lat_reg;
		a_cap_next   = a_cap_reg;
		b_cap_next   = b_cap_reg;
		a_full_next  = a_full_reg;
		b_full_next  = b_full_reg;
		a_intr_next  = a_intr_reg;
		b_intr_next  = b_intr_reg;
		prdata_next  = prdata_reg;
		pready_next  = 1'b0;
		pslverr_next = 1'b0;

		// Bus answer: one wait state, data captured before the final edge
		if (acc_wait) begin
			pready_next  = 1'b1;
			pslverr_next = ~hit_any;
			prdata_next  = 32'h0000_0000;
			if (hit_a) begin
				// Strobed input shows the captured byte, else line levels
				prdata_next[7:0] = (a_hs & a_in) ? a_cap_reg : a_s2_reg;  // [RQ3]
			end else if (hit_b) begin
				prdata_next[7:0] = (b_hs & b_in) ? b_cap_reg : b_s2_reg;  // [RQ5]
			end else if (hit_c) begin
				// Driven bits read back their own drive, the rest the pins
				for (int i = 0; i < 8; i++) begin
					prdata_next[i] = c_oe_reg[i] ? c_out_reg[i] : c_s2_reg[i];  // [RQ7] [RQ8]
				end
			end else if (hit_cw) begin
				prdata_next[7:0] = cw_reg;  // [RQ9]
			end
		end
		// Host reads that empty a strobed input buffer
		if (rd_ok & hit_a & a_hs & a_in) begin
			a_full_next = 1'b0;
			a_intr_next = 1'b0;
		end
		if (rd_ok & hit_b & b_hs & b_in) begin
			b_full_next = 1'b0;
			b_intr_next = 1'b0;
		end
		// Host writes
		if (wr_ok & hit_a) begin
			a_lat_next = pwdata[7:0];  // [RQ4]
			if (a_hs & ~a_in) begin
				a_intr_next = 1'b0;
			end
		end
		if (wr_ok & hit_b) begin
			b_lat_next = pwdata[7:0];  // [RQ6]
			if (b_hs & ~b_in) begin
				b_intr_next = 1'b0;
			end
		end
		if (wr_ok & hit_c) begin
			c_lat_next = pwdata[7:0];  // [RQ7]
		end
		if (wr_ok & hit_cw) begin
			if (pwdata[CW_DEFINE]) begin
				// Mode definition clears latches and handshake state
				cw_next     = pwdata[7:0];  // [RQ9] [RQ10]
				a_lat_next  = 8'h00;
				b_lat_next  = 8'h00;
				c_lat_next  = 8'h00;
				a_full_next = 1'b0;
				b_full_next = 1'b0;
				a_intr_next = 1'b0;
				b_intr_next = 1'b0;
			end else begin
				c_lat_next[bit_sel] = pwdata[CW_BIT_VAL];  // [RQ10]
			end
		end
		// Port A handshake events; a write fills the output buffer
		if (a_hs) begin
			if (a_in) begin
				if (stb_a_fall) begin
					a_cap_next  = a_s2_reg;
					a_full_next = 1'b1;  // [RQ8]
				end
			end else begin
				if (wr_ok & hit_a) begin
					a_full_next = 1'b1;
				end else if (stb_a_fall) begin
					a_full_next = 1'b0;  // [RQ8]
				end
			end
			if (stb_a_rise & inte_a) begin
				a_intr_next = 1'b1;
			end
		end
		// Port B handshake events
		if (b_hs) begin
			if (b_in) begin
				if (stb_b_fall) begin
					b_cap_next  = b_s2_reg;
					b_full_next = 1'b1;  // [RQ8]
				end
			end else begin
				if (wr_ok & hit_b) begin
					b_full_next = 1'b1;
				end else if (stb_b_fall) begin
					b_full_next = 1'b0;  // [RQ8]
				end
			end
			if (stb_b_rise & inte_b) begin
				b_intr_next = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	// Computed from the next control word so a direction change and
	// its drive take effect together
	always_comb begin
		a_oe_next  = {8{~cw_next[CW_A_IN]}};  // [RQ4] [RQ9]
		b_oe_next  = {8{~cw_next[CW_B_IN]}};  // [RQ6] [RQ9]
		c_out_next = c_lat_next;
		c_oe_next  = {{4{~cw_next[CW_CU_IN]}}, {4{~cw_next[CW_CL_IN]}}};  // [RQ7]
		if (a_strobed(cw_next)) begin
			c_out_next[PC_INTR_A] = a_intr_next;  // [RQ8]
			c_oe_next[PC_INTR_A]  = 1'b1;
			if (cw_next[CW_A_IN]) begin
				c_out_next[PC_IBF_A]  = a_full_next;
				c_oe_next[PC_IBF_A]   = 1'b1;
				c_oe_next[PC_STB_A_N] = 1'b0;
			end else begin
				c_out_next[PC_OBF_A_N] = ~a_full_next;
				c_oe_next[PC_OBF_A_N]  = 1'b1;
				c_oe_next[PC_ACK_A_N]  = 1'b0;
			end
		end
		if (b_strobed(cw_next)) begin
			c_out_next[PC_INTR_B] = b_intr_next;  // [RQ8]
			c_oe_next[PC_INTR_B]  = 1'b1;
			c_out_next[PC_FLAG_B] = cw_next[CW_B_IN] ? b_full_next : ~b_full_next;
			c_oe_next[PC_FLAG_B]  = 1'b1;
			c_oe_next[PC_HS_B_N]  = 1'b0;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Synchronisers: the first stage feeds only the second
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			a_s1_reg   <= 8'h00;
			a_s2_reg   <= 8'h00;
			b_s1_reg   <= 8'h00;
			b_s2_reg   <= 8'h00;
			c_s1_reg   <= 8'hff;  // Idle level of the active-low strobes
			c_s2_reg   <= 8'hff;
			c_prev_reg <= 8'hff;  // Matches the idle pin, so no false edge after reset
		end else begin
			a_s1_reg   <= first_port_lines_in;
			a_s2_reg   <= a_s1_reg;
			b_s1_reg   <= second_port_lines_in;
			b_s2_reg   <= b_s1_reg;
			c_s1_reg   <= third_port_lines_in;
			c_s2_reg   <= c_s1_reg;
			c_prev_reg <= c_s2_reg;
		end
	end
	// Control, latches and bus answer
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cw_reg      <= CW_RESET;
			a_lat_reg   <= 8'h00;
			b_lat_reg   <= 8'h00;
			c_lat_reg   <= 8'h00;
			a_cap_reg   <= 8'h00;
			b_cap_reg   <= 8'h00;
			a_full_reg  <= 1'b0;
			b_full_reg  <= 1'b0;
			a_intr_reg  <= 1'b0;
			b_intr_reg  <= 1'b0;
			a_oe_reg    <= 8'h00;
			b_oe_reg    <= 8'h00;
			c_out_reg   <= 8'h00;
			c_oe_reg    <= 8'h00;
			prdata_reg  <= 32'h0000_0000;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			cw_reg      <= cw_next;
			a_lat_reg   <= a_lat_next;
			b_lat_reg   <= b_lat_next;
			c_lat_reg   <= c_lat_next;
			a_cap_reg   <= a_cap_next;
			b_cap_reg   <= b_cap_next;
			a_full_reg  <= a_full_next;
			b_full_reg  <= b_full_next;
			a_intr_reg  <= a_intr_next;
			b_intr_reg  <= b_intr_next;
			a_oe_reg    <= a_oe_next;
			b_oe_reg    <= b_oe_next;
			c_out_reg   <= c_out_next;
			c_oe_reg    <= c_oe_next;
			prdata_reg  <= prdata_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prdata                = prdata_reg;
	assign pready                = pready_reg;
	assign pslverr               = pslverr_reg;
	assign first_port_lines_out  = a_lat_reg;
	assign first_port_lines_oe   = a_oe_reg;
	assign second_port_lines_out = b_lat_reg;
	assign second_port_lines_oe  = b_oe_reg;
	assign third_port_lines_out  = c_out_reg;
	assign third_port_lines_oe   = c_oe_reg;
endmodule : pdio_ports
`default_nettype wire

// file: verif/pdio_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Far side of one 8-line port
// ----------------------------------------
module pdio_pins_model (
	input  wire logic [7:0] line_out, // Level the device drives
	input  wire logic [7:0] line_oe,  // High where the device drives
	input  wire logic [7:0] ext,      // Level the peer drives elsewhere
	output logic      [7:0] line_in   // Resolved wire level
);
	// The peer lets go of every line the device drives, so no contention
	assign line_in = (line_oe & line_out) | (~line_oe & ext);
endmodule : pdio_pins_model
`default_nettype wire

// file: verif/pdio_ports_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pdio_ports_assertions
	import pdio_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              rstn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	input  wire logic [31:0]       prdata,
	input  wire logic              pready,
	input  wire logic              pslverr,
	input  wire logic [7:0]        first_port_lines_in,
	input  wire logic [7:0]        first_port_lines_out,
	input  wire logic [7:0]        first_port_lines_oe,
	input  wire logic [7:0]        second_port_lines_oe,
	input  wire logic [7:0]        third_port_lines_out,
	input  wire logic [7:0]        third_port_lines_oe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	logic       done;            // Access phase ends here
	logic       wr_ok;           // Write that takes effect
	logic       mapped;          // One of the four registers
	logic [7:0] wbyte;           // Low write lane
	logic [7:0] cw_reg, cw_next; // Last mode definition
	logic [7:0] ain_reg;         // Port A pins one edge ago
	logic [2:0] st_reg, st_next; // Edges port A pins held still
	assign done   = psel && penable && pready;
	assign wr_ok  = done && pwrite && pstrb[0];
	assign mapped = paddr inside {OFS_PORT_A, OFS_PORT_B, OFS_PORT_C, OFS_CFG};
	assign wbyte  = pwdata[7:0];
	// Next mode word; stability count saturates so it never wraps
	always_comb begin
		cw_next = (wr_ok && paddr == OFS_CFG && wbyte[7]) ? wbyte : cw_reg;
		st_next = (first_port_lines_in != ain_reg) ? 3'h0 : st_reg + {2'h0, st_reg != 3'h7};
	end
	// Register helpers; mode word mirrors the design's reset word
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cw_reg  <= CW_RESET;
			st_reg  <= 3'h0;
			ain_reg <= 8'h00;
		end else begin
			cw_reg  <= cw_next;
			st_reg  <= st_next;
			ain_reg <= first_port_lines_in;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	chk_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready missing after first access cycle");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	chk_map_err: assert property (done |-> pslverr == !mapped && prdata[31:8] == 24'h0)
		else $error("error flag or upper read lanes wrong");
	chk_a_drive: assert property (wr_ok && paddr == OFS_PORT_A && !cw_reg[4]
		|=> first_port_lines_out == $past(wbyte) && first_port_lines_oe == 8'hff)
		else $error("port A write not driven");
	chk_a_read: assert property (done && !pwrite && paddr == OFS_PORT_A
		&& cw_reg[6:5] == 2'b00 && st_reg > 3'h5 && first_port_lines_in == ain_reg
		|-> prdata[7:0] == first_port_lines_in)
		else $error("port A read differs from pins");
	chk_cfg_dirs: assert property (wr_ok && paddr == OFS_CFG && wbyte[7]
		&& wbyte[6:5] == 2'b00 && !wbyte[2] |=> first_port_lines_oe == {8{!cw_reg[4]}}
		&& second_port_lines_oe == {8{!cw_reg[1]}}
		&& third_port_lines_oe == {{4{!cw_reg[3]}}, {4{!cw_reg[0]}}})
		else $error("directions differ from control word");
	chk_c_bitop: assert property (wr_ok && paddr == OFS_CFG && !wbyte[7]
		&& cw_reg[6:5] == 2'b00 && !cw_reg[2]
		|=> third_port_lines_out[$past(pwdata[3:1])] == $past(pwdata[0]))
		else $error("port C single bit not applied");
	chk_c_handshake: assert property (wr_ok && paddr == OFS_CFG && wbyte[7:4] == 4'hb
		|=> third_port_lines_oe[5] && third_port_lines_oe[3] && !third_port_lines_oe[4])
		else $error("port C handshake lines not taken over");
	cov_read_a: cover property (done && !pwrite && paddr == OFS_PORT_A);
	cov_unmapped: cover property (done && pslverr);
	cov_bitop: cover property (wr_ok && paddr == OFS_CFG && !wbyte[7]);
endmodule : pdio_ports_assertions
bind pdio_ports pdio_ports_assertions u_pdio_ports_assertions (.*);
`default_nettype wire

// file: verif/pdio_ports_test.sv
`timescale 1ns/1ps
`default_nettype none
module pdio_ports_test
	import pdio_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        core_clk, rstn, psel, penable, pwrite, pready, pslverr, er;
	logic [19:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic [7:0]  a_in, a_out, a_oe, b_in, b_out, b_oe, c_in, c_out, c_oe;
	logic [7:0]  a_ext, b_ext, c_ext, cx; // Peer levels, expected C latch
	int          num_errors = 0;
	int          samples_checked = 0;
	pdio_ports u_pdio_ports (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .first_port_lines_in(a_in),
		.first_port_lines_out(a_out), .first_port_lines_oe(a_oe), .second_port_lines_in(b_in),
		.second_port_lines_out(b_out), .second_port_lines_oe(b_oe), .third_port_lines_in(c_in),
		.third_port_lines_out(c_out), .third_port_lines_oe(c_oe));
	pdio_pins_model u_pins_a (.line_out(a_out), .line_oe(a_oe), .ext(a_ext), .line_in(a_in));
	pdio_pins_model u_pins_b (.line_out(b_out), .line_oe(b_oe), .ext(b_ext), .line_in(b_in));
	pdio_pins_model u_pins_c (.line_out(c_out), .line_oe(c_oe), .ext(c_ext), .line_in(c_in));
	// 200 MHz clock
	initial core_clk = 1'b0;
	always #2.5 core_clk = ~core_clk;
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic conclude;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask : chk
	// One APB transfer; bounded wait since the slave sets the pace
	task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// A slave that never answers ends the run here as a mismatch
		if (n >= 50) begin
			$display("mismatch at %0t: no pready", $time);
			num_errors++;
			conclude();
		end
	endtask : xfer
	task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic [3:0] s);
		xfer(1'b1, a, {24'h0, d}, s);
	endtask : wr
	task automatic rdc(input logic [19:0] a, input logic [31:0] exp, input logic e);
		xfer(1'b0, a, 32'h0, 4'h0);
		chk(rd, exp);
		chk({31'h0, er}, {31'h0, e});
	endtask : rdc
	// Let pin updates and the two input flops settle; values seen here
	// were launched at an earlier edge, so nothing races the clock
	task automatic settle(input int c);
		repeat (c) @(posedge core_clk);
	endtask : settle
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 20'h0; pwdata = 32'h0; pstrb = 4'h0;
		a_ext = 8'h5a; b_ext = 8'ha5; c_ext = 8'h3c; cx = 8'h71;
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		chk({8'h0, a_oe, b_oe, c_oe}, 32'h0);
		rdc(OFS_CFG, 32'h9b, 1'b0);
		rdc(OFS_PORT_A, 32'h5a, 1'b0);
		rdc(OFS_PORT_B, 32'ha5, 1'b0);
		rdc(OFS_PORT_C, 32'h3c, 1'b0);
		wr(OFS_CFG, 8'h80, 4'h1);
		settle(2);
		chk({8'h0, a_oe, b_oe, c_oe}, 32'hffffff);
		rdc(OFS_CFG, 32'h80, 1'b0);
		wr(OFS_PORT_A, 8'hc3, 4'h1);
		wr(OFS_PORT_B, 8'h96, 4'h1);
		wr(OFS_PORT_C, 8'h71, 4'h1);
		wr(OFS_PORT_A, 8'h00, 4'he); // Lane 0 not strobed: ignored
		settle(2);
		chk({8'h0, a_out, b_out, c_out}, 32'hc39671);
		rdc(OFS_PORT_A, 32'hc3, 1'b0);
		// Toggle every port C bit through single bit operations
		for (int i = 0; i < 8; i++) begin
			cx[i] = ~cx[i];
			wr(OFS_CFG, {4'h0, 3'(i), cx[i]}, 4'h1);
			settle(2);
			chk({24'h0, c_out}, {24'h0, cx});
		end
		rdc(20'h50040, 32'h0, 1'b1);
		wr(20'h50004, 8'hff, 4'h1);
		chk({31'h0, er}, 32'h1);
		rdc(OFS_PORT_A, 32'hc3, 1'b0);
		// Strobed input on port A, handshakes on port C
		wr(OFS_CFG, 8'hb0, 4'h1);
		settle(2);
		chk({24'h0, c_oe & 8'h38}, 32'h28);
		a_ext <= 8'h3e;
		c_ext <= 8'hff;
		settle(4);
		c_ext <= 8'hef; // Strobe low captures the byte
		settle(4);
		c_ext <= 8'hff;
		settle(4);
		a_ext <= 8'h00; // Live pins move away from the capture
		settle(4);
		chk({31'h0, c_out[5]}, 32'h1);
		rdc(OFS_PORT_A, 32'h3e, 1'b0);
		settle(2);
		chk({31'h0, c_out[5]}, 32'h0);
		// Strobed output on port A: a write fills, acknowledge empties
		wr(OFS_CFG, 8'ha0, 4'h1);
		wr(OFS_PORT_A, 8'h4b, 4'h1);
		settle(2);
		chk({23'h0, a_out, c_out[7]}, {23'h0, 8'h4b, 1'b0});
		c_ext <= 8'hbf; // Acknowledge low empties the buffer
		settle(4);
		chk({31'h0, c_out[7]}, 32'h1);
		// Strobed input on port B with its request enabled
		wr(OFS_CFG, 8'h86, 4'h1);
		wr(OFS_CFG, 8'h05, 4'h1);
		b_ext <= 8'h69;
		settle(4);
		c_ext <= 8'hfb; // Strobe low captures the byte
		settle(4);
		c_ext <= 8'hff; // Strobe rise raises the request
		settle(4);
		b_ext <= 8'h00; // Live pins move away from the capture
		settle(4);
		chk({30'h0, c_out[1:0]}, 32'h3);
		rdc(OFS_PORT_B, 32'h69, 1'b0);
		settle(2);
		chk({30'h0, c_out[1:0]}, 32'h0);
		conclude();
	end
endmodule : pdio_ports_test
`default_nettype wire
